// *** rtl/wws_regs.svh ***
// Constants of the windowed watchdog supervisor
//
// Summary of operation
// - Power-good drops when an enabled output falls under 98% (ch 1) or 95%.
// - Power-good returns only above 98.3% or 95.3%, a 0.3% hysteresis.
// - A reset output asserts only after power-good stayed low over 100 us.
// - Reset output releases once power-good stayed high for the reset delay.
// - A disabled or unused channel holds its reset output low.
// - Reset release delay equals the watchdog timeout period.
// - The watchdog acts only on a falling edge of the kick input.
// - On timeout the watchdog reset is low one period, then released.
// - After power-up the watchdog starts in timeout with its reset low.
// - A kick before the lower window boundary causes a full reset pulse.
// - After a reset pulse a fresh lower boundary interval starts.
// - The lower boundary lasts exactly a quarter of the timeout period.
// - A kick after the lower boundary restarts counter and lower interval.
// - No kick within eight periods after a valid kick starts a timeout.
// - After a timeout pulse up to 64 periods are allowed for a kick.
// - Base timeout period is set as by the timing_cap, 202 ms at 10 nF.
`ifndef WWS_REGS_SVH
`define WWS_REGS_SVH

// ****************************************
// Timing
// ****************************************
`define WWS_CLK_PERIOD_NS 10
`define WWS_TICK_NS 1000
`define WWS_TICK_CYCLES (`WWS_TICK_NS / `WWS_CLK_PERIOD_NS)
`define WWS_TIMEOUT_US 202000
`define WWS_FILTER_US 100
`define WWS_LOWER_DIV 4
`define WWS_UPPER_MULT 8
`define WWS_LONG_MULT 64

// ****************************************
// Output level thresholds, units of 0.1 % of target
// ****************************************
`define WWS_LVL_W 11
`define WWS_FALL_CH1 980
`define WWS_FALL_OTHER 950
`define WWS_HYST 3

`endif

// *** rtl/wws_pkg.sv ***
// Types of the windowed watchdog supervisor
package wws_pkg;

  typedef enum logic [1:0] {
    WWS_DOG_RESET = 2'b00,
    WWS_DOG_LOWER = 2'b01,
    WWS_DOG_OPEN = 2'b10
  } wws_dog_e;

  typedef struct packed {
    logic ok;
    logic [31:0] low_cnt;
    logic [31:0] high_cnt;
    logic rst_n;
  } wws_chan_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } wws_tick_s;

endpackage : wws_pkg

// *** rtl/wws_tick.sv ***
// Prescaler giving one-cycle microsecond ticks
`timescale 1ns/1ns
`default_nettype none
`include "wws_regs.svh"

module wws_tick #(
  parameter int unsigned CYCLES = `WWS_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  output logic tick
);

  generate
    if (CYCLES < 2 || CYCLES > 256) begin : g_bad
      $error("wws_tick: CYCLES out of range");
    end
  endgenerate

  wws_pkg::wws_tick_s st_q;
  wws_pkg::wws_tick_s st_d;

  // Single prescaler shared by every interval
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == 8'(CYCLES - 1)) begin
      st_d.cnt = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;

  tick_period_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    st_q.tick |-> st_q.cnt == 8'h00)
    else $error("tick not aligned to prescaler wrap");

endmodule : wws_tick

`default_nettype wire

// *** rtl/wws_chan.sv ***
// Power-good hysteresis and reset output filter of one channel
`timescale 1ns/1ns
`default_nettype none
`include "wws_regs.svh"

module wws_chan #(
  parameter int unsigned FALL_LVL = `WWS_FALL_OTHER,
  parameter int unsigned FILTER_US = `WWS_FILTER_US,
  parameter int unsigned DELAY_US = `WWS_TIMEOUT_US
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic chan_en,
  input wire logic [`WWS_LVL_W-1:0] chan_level,
  output logic output_ok,
  output logic rst_n
);

  generate
    if (FILTER_US < 1 || DELAY_US < 1 || FALL_LVL + `WWS_HYST >= 2 ** `WWS_LVL_W) begin : g_bad
      $error("wws_chan: bad parameters");
    end
  endgenerate

  wws_pkg::wws_chan_s st_q;
  wws_pkg::wws_chan_s st_d;

  always_comb begin
    st_d = st_q;
    // ****************************************
    // Comparator with hysteresis
    // ****************************************
    if (!chan_en) begin
      st_d.ok = 1'b0;
    end else if (st_q.ok && 32'(chan_level) < FALL_LVL) begin
      st_d.ok = 1'b0;
    end else if (!st_q.ok && 32'(chan_level) > FALL_LVL + `WWS_HYST) begin
      st_d.ok = 1'b1;
    end
    // ****************************************
    // Reset output filter
    // ****************************************
    if (!chan_en) begin
      st_d.rst_n = 1'b0;
      st_d.low_cnt = '0;
      st_d.high_cnt = '0;
    end else if (st_q.ok) begin
      st_d.low_cnt = '0;
      if (!st_q.rst_n && tick) begin
        if (st_q.high_cnt + 32'h1 >= DELAY_US) begin
          st_d.rst_n = 1'b1;
          st_d.high_cnt = '0;
        end else begin
          st_d.high_cnt = st_q.high_cnt + 32'h1;
        end
      end
    end else begin
      st_d.high_cnt = '0;
      if (st_q.rst_n && tick) begin
        if (st_q.low_cnt >= FILTER_US) begin
          st_d.rst_n = 1'b0;
          st_d.low_cnt = '0;
        end else begin
          st_d.low_cnt = st_q.low_cnt + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign output_ok = st_q.ok;
  assign rst_n = st_q.rst_n;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  fall_drop_a: assert property (chan_en && st_q.ok && 32'(chan_level) < FALL_LVL |=> !st_q.ok)
    else $error("power-good did not drop under threshold");
  hyst_hold_a: assert property (chan_en && !st_q.ok && 32'(chan_level) <= FALL_LVL + `WWS_HYST
    |=> !st_q.ok)
    else $error("power-good rose inside hysteresis band");
  filter_len_a: assert property ($fell(st_q.rst_n) && $past(chan_en) |-> $past(st_q.low_cnt) >= FILTER_US)
    else $error("reset asserted before filter time");
  release_len_a: assert property ($rose(st_q.rst_n) |-> $past(st_q.high_cnt) == DELAY_US - 1)
    else $error("reset released at wrong delay");
  disabled_low_a: assert property (!chan_en |=> !st_q.rst_n && !st_q.ok)
    else $error("disabled channel reset not held low");

endmodule : wws_chan

`default_nettype wire

// *** rtl/wws_top.sv ***
// Windowed watchdog and channel reset supervisor, top level
`timescale 1ns/1ns
`default_nettype none
`include "wws_regs.svh"

module wws_top #(
  parameter int unsigned TIMEOUT_US = `WWS_TIMEOUT_US,
  parameter int unsigned FILTER_US = `WWS_FILTER_US,
  parameter int unsigned CHANNELS = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic kick_input,
  input wire logic [CHANNELS-1:0] chan_en,
  input wire logic [CHANNELS*`WWS_LVL_W-1:0] chan_level,
  output logic dog_reset_n,
  output logic [CHANNELS-1:0] rst_n,
  output logic [CHANNELS-1:0] output_ok
);

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if (TIMEOUT_US < `WWS_LOWER_DIV || TIMEOUT_US % `WWS_LOWER_DIV != 0
        || TIMEOUT_US > 32'd60000000) begin : g_bad_timeout
      $error("wws_top: TIMEOUT_US must be a multiple of 4 and fit the counter");
    end
    if (FILTER_US < 1 || CHANNELS < 1 || CHANNELS > 8) begin : g_bad_other
      $error("wws_top: bad FILTER_US or CHANNELS");
    end
  endgenerate

  // Base period as set by timing_cap
  localparam int unsigned LOWER_US = TIMEOUT_US / `WWS_LOWER_DIV;
  localparam int unsigned UPPER_US = TIMEOUT_US * `WWS_UPPER_MULT;
  localparam int unsigned LONG_US = TIMEOUT_US * `WWS_LONG_MULT;

  typedef struct packed {
    logic kick_s1;
    logic kick_s2;
    logic kick_prev;
    logic [CHANNELS-1:0] en_s1;
    logic [CHANNELS-1:0] en_s2;
    wws_pkg::wws_dog_e state;
    logic long_win;
    logic [31:0] cnt;
    logic dog_n;
  } wws_top_s;

  wws_top_s st_q;
  wws_top_s st_d;
  logic tick;
  logic kick_fall;

  // ****************************************
  // Shared prescaler
  // ****************************************
  wws_tick #(
    .CYCLES(`WWS_TICK_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // Edge of the synchronised kick, never of the first stage
  assign kick_fall = st_q.kick_prev && !st_q.kick_s2;

  // ****************************************
  // Watchdog state machine
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.kick_s1 = kick_input;
    st_d.kick_s2 = st_q.kick_s1;
    st_d.kick_prev = st_q.kick_s2;
    st_d.en_s1 = chan_en;
    st_d.en_s2 = st_q.en_s1;
    case (st_q.state)
      wws_pkg::WWS_DOG_RESET: begin
        // Kicks ignored while the reset pulse runs
        st_d.dog_n = 1'b0;
        if (tick) begin
          if (st_q.cnt + 32'h1 >= TIMEOUT_US) begin
            st_d.state = wws_pkg::WWS_DOG_LOWER;
            st_d.cnt = '0;
            st_d.long_win = 1'b1;
            st_d.dog_n = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + 32'h1;
          end
        end
      end
      wws_pkg::WWS_DOG_LOWER: begin
        if (kick_fall) begin
          st_d.state = wws_pkg::WWS_DOG_RESET;
          st_d.cnt = '0;
          st_d.dog_n = 1'b0;
        end else if (tick) begin
          st_d.cnt = st_q.cnt + 32'h1;
          if (st_q.cnt + 32'h1 >= LOWER_US) begin
            st_d.state = wws_pkg::WWS_DOG_OPEN;
          end
        end
      end
      wws_pkg::WWS_DOG_OPEN: begin
        if (kick_fall) begin
          st_d.state = wws_pkg::WWS_DOG_LOWER;
          st_d.cnt = '0;
          st_d.long_win = 1'b0;
        end else if (tick) begin
          if (st_q.cnt + 32'h1 >= (st_q.long_win ? LONG_US : UPPER_US)) begin
            st_d.state = wws_pkg::WWS_DOG_RESET;
            st_d.cnt = '0;
            st_d.dog_n = 1'b0;
          end else begin
            st_d.cnt = st_q.cnt + 32'h1;
          end
        end
      end
      default: begin
        st_d.state = wws_pkg::WWS_DOG_RESET;
        st_d.cnt = '0;
        st_d.dog_n = 1'b0;
      end
    endcase
  end

  // Power-up lands in the timeout state, output low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{kick_s1: 1'b1, kick_s2: 1'b1, kick_prev: 1'b1, en_s1: '0, en_s2: '0,
                state: wws_pkg::WWS_DOG_RESET, long_win: 1'b1, cnt: 32'h0, dog_n: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign dog_reset_n = st_q.dog_n;

  // ****************************************
  // Channel supervisors
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      wws_chan #(
        .FALL_LVL(gi == 0 ? `WWS_FALL_CH1 : `WWS_FALL_OTHER),
        .FILTER_US(FILTER_US),
        .DELAY_US(TIMEOUT_US)
      ) u_chan (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .tick(tick),
        .chan_en(st_q.en_s2[gi]),
        .chan_level(chan_level[gi*`WWS_LVL_W +: `WWS_LVL_W]),
        .output_ok(output_ok[gi]),
        .rst_n(rst_n[gi])
      );
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  logic seen_lower_q;
  logic [31:0] low_len_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_lower_q <= 1'b0;
    end else if (st_d.state == wws_pkg::WWS_DOG_LOWER) begin
      // Set with the first lower window cycle so powerup_a never overlaps it
      seen_lower_q <= 1'b1;
    end
  end

  // Ticks spent low on the watchdog output
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_len_q <= 32'h0;
    end else if (st_q.dog_n) begin
      low_len_q <= 32'h0;
    end else if (tick) begin
      low_len_q <= low_len_q + 32'h1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  reset_low_a: assert property (st_q.state == wws_pkg::WWS_DOG_RESET |-> !dog_reset_n)
    else $error("watchdog reset high in timeout state");
  pulse_len_a: assert property ($rose(dog_reset_n) |-> $past(low_len_q) == TIMEOUT_US - 1)
    else $error("watchdog reset pulse has wrong length");
  powerup_a: assert property (!seen_lower_q |-> st_q.state == wws_pkg::WWS_DOG_RESET
    && !dog_reset_n)
    else $error("watchdog did not start in timeout");
  early_kick_a: assert property (st_q.state == wws_pkg::WWS_DOG_LOWER && kick_fall
    |=> st_q.state == wws_pkg::WWS_DOG_RESET && !dog_reset_n)
    else $error("early kick not treated as failure");
  fresh_lower_a: assert property ($rose(dog_reset_n)
    |-> st_q.state == wws_pkg::WWS_DOG_LOWER && st_q.cnt == 32'h0)
    else $error("no fresh lower interval after pulse");
  lower_len_a: assert property (st_q.state == wws_pkg::WWS_DOG_OPEN
    && $past(st_q.state) == wws_pkg::WWS_DOG_LOWER |-> st_q.cnt == LOWER_US)
    else $error("lower boundary length wrong");
  valid_kick_a: assert property (st_q.state == wws_pkg::WWS_DOG_OPEN && kick_fall
    |=> st_q.state == wws_pkg::WWS_DOG_LOWER && st_q.cnt == 32'h0 && !st_q.long_win
    && dog_reset_n)
    else $error("valid kick did not restart window");
  level_only_a: assert property (st_q.state == wws_pkg::WWS_DOG_OPEN && !kick_fall
    |=> st_q.state != wws_pkg::WWS_DOG_LOWER)
    else $error("watchdog serviced without falling edge");
  upper_short_a: assert property (st_q.state == wws_pkg::WWS_DOG_OPEN && !st_q.long_win
    |-> st_q.cnt < UPPER_US)
    else $error("upper boundary after kick overrun");
  upper_expire_a: assert property (st_q.state == wws_pkg::WWS_DOG_OPEN && !kick_fall && tick
    && st_q.cnt == (st_q.long_win ? LONG_US : UPPER_US) - 1
    |=> st_q.state == wws_pkg::WWS_DOG_RESET && !dog_reset_n)
    else $error("missing kick did not start timeout");

  early_kick_c: cover property (st_q.state == wws_pkg::WWS_DOG_LOWER && kick_fall && seen_lower_q);
  valid_kick_c: cover property (st_q.state == wws_pkg::WWS_DOG_OPEN && kick_fall);
  short_expire_c: cover property (st_q.state == wws_pkg::WWS_DOG_OPEN && !st_q.long_win
    ##1 st_q.state == wws_pkg::WWS_DOG_RESET);
  chan_release_c: cover property ($rose(rst_n[0]));

endmodule : wws_top

`default_nettype wire

// *** test/wws_cpu_model.sv ***
// Processor model that services the watchdog kick pin
`timescale 1ns/1ns
`default_nettype none

module wws_cpu_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [31:0] wait_cyc,
  input wire logic [31:0] low_cyc,
  output logic kick_input,
  output logic busy
);
  // One kick per request: wait, pull the pin low, hold, let it go high
  initial begin
    kick_input = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go === 1'b1) begin
        busy = 1'b1;
        repeat (wait_cyc) @(posedge sys_clk);
        #1 kick_input = 1'b0;
        repeat (low_cyc) @(posedge sys_clk);
        #1 kick_input = 1'b1;
        busy = 1'b0;
      end
    end
  end
endmodule : wws_cpu_model
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the windowed watchdog supervisor
`timescale 1ns/1ns
`default_nettype none
`include "wws_regs.svh"
`define TB_CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
  localparam int TK = 100;
  localparam int TP = 8 * TK;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic go = 1'b0;
  logic busy;
  logic kick_input;
  logic [31:0] wait_c = 32'h0;
  logic [31:0] low_c = 32'h0;
  logic [3:0] chan_en = 4'hF;
  logic [10:0] lvl [4] = '{default: 11'h3E8};
  logic [43:0] chan_level;
  logic dog_reset_n;
  logic [3:0] rst_n;
  logic [3:0] output_ok;
  logic [3:0] exp_ok;
  int n_fail = 0;
  int total_checks = 0;
  int seed = 32'h6478;
  int n;

  assign chan_level = {lvl[3], lvl[2], lvl[1], lvl[0]};

  wws_top #(.TIMEOUT_US(8), .FILTER_US(5), .CHANNELS(4)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .kick_input(kick_input),
    .chan_en(chan_en), .chan_level(chan_level), .dog_reset_n(dog_reset_n),
    .rst_n(rst_n), .output_ok(output_ok));

  wws_cpu_model cpu (.sys_clk(sys_clk), .go(go), .wait_cyc(wait_c), .low_cyc(low_c),
    .kick_input(kick_input), .busy(busy));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  function automatic int urand(input int m);
    return $unsigned($random(seed)) % m;
  endfunction : urand

  // Hysteresis of one channel's power-good
  function automatic logic model_ok(input int c, input logic prev);
    int f;
    f = (c == 0) ? `WWS_FALL_CH1 : `WWS_FALL_OTHER;
    if (chan_en[c] !== 1'b1 || lvl[c] < f) return 1'b0;
    if (lvl[c] > f + `WWS_HYST) return 1'b1;
    return prev;
  endfunction : model_ok

  task automatic end_test(input string nm);
    $display("test %s done, checks %0d mismatches %0d", nm, total_checks, n_fail);
  endtask : end_test

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  // Cycles until the watchdog output reaches a level, bounded
  task automatic wait_dog(input logic v, input int lim);
    n = 0;
    while (dog_reset_n !== v && n < lim) begin
      wait_cyc(1);
      n++;
    end
  endtask : wait_dog

  task automatic do_kick(input int w, input int l);
    int k;
    wait_c = w;
    low_c = l;
    go = 1'b1;
    wait_cyc(1);
    go = 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 100000) begin
      wait_cyc(1);
      k++;
    end
  endtask : do_kick

  task automatic chk_rng(input string nm, input int v, input int lo, input int hi);
    `TB_CHK(nm, 1'b1, (v >= lo && v <= hi))
  endtask : chk_rng

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    wait_dog(1'b1, TP + 50);
    chk_rng("power_up_low", n, TP - 5, TP + 5);
    end_test("power_up");
    repeat (2) begin
      do_kick(urand(40), 10);
      `TB_CHK("early_kick", 1'b0, dog_reset_n);
      wait_dog(1'b1, TP + 50);
      chk_rng("fail_pulse", n, TP - 110, TP);
    end
    repeat (3) begin
      do_kick(300 + urand(1500), 5 + urand(300));
      `TB_CHK("valid_kick", 1'b1, dog_reset_n);
    end
    do_kick(300, 10);
    do_kick(urand(50), 10);
    `TB_CHK("lower_window", 1'b0, dog_reset_n);
    wait_dog(1'b1, TP + 50);
    do_kick(400, 10);
    wait_dog(1'b0, 8 * TP + 200);
    chk_rng("upper_window", n, 8 * TP - 110, 8 * TP);
    wait_dog(1'b1, TP + 50);
    chk_rng("timeout_pulse", n, TP - 100, TP + 2);
    wait_dog(1'b0, 64 * TP + 200);
    chk_rng("long_window", n, 64 * TP - 100, 64 * TP + 2);
    wait_dog(1'b1, TP + 50);
    end_test("watchdog");
    chan_en = 4'h7;
    wait_cyc(5);
    exp_ok = 4'h7;
    repeat (300) begin
      for (int c = 0; c < 4; c++) lvl[c] = 11'((c == 0 ? 970 : 940) + urand(21));
      wait_cyc(1);
      for (int c = 0; c < 4; c++) exp_ok[c] = model_ok(c, exp_ok[c]);
      `TB_CHK("output_ok", exp_ok, output_ok);
      `TB_CHK("idle_reset", 1'b0, rst_n[3]);
    end
    end_test("power_good");
    chan_en = 4'hF;
    for (int c = 0; c < 4; c++) lvl[c] = 11'h3E8;
    wait_cyc(TP - 120);
    `TB_CHK("release_early", 1'b0, rst_n[3]);
    wait_cyc(220);
    `TB_CHK("release", 4'hF, rst_n);
    lvl[1] = 11'h384;
    wait_cyc(3 * TK);
    lvl[1] = 11'h3E8;
    `TB_CHK("short_drop", 1'b1, rst_n[1]);
    wait_cyc(2 * TK);
    lvl[1] = 11'h384;
    wait_cyc(4 * TK);
    `TB_CHK("filter_hold", 1'b1, rst_n[1]);
    wait_cyc(4 * TK);
    `TB_CHK("filter_fire", 1'b0, rst_n[1]);
    end_test("reset_filter");
    tally_and_finish();
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    #(100000 * 10);
    n_fail++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
